// [wakeup_route_cfg.svh]
// Offsets, field positions and reset values for the wake-up routing block
`ifndef WAKEUP_ROUTE_CFG_SVH
`define WAKEUP_ROUTE_CFG_SVH

// ==========================================================
// Register byte offsets
`define OFS_LINE_SELECT 12'h0B0
`define OFS_ANALOG_ENABLE 12'h0BC
`define OFS_EVENT_STATUS 12'h0C0
`define OFS_EVENT_MASK 12'h0C4

// ==========================================================
// Field layout
`define SEL_WIDTH 3
`define SEL3_LSB 0
`define SEL5_LSB 3
`define SEL6_LSB 6
`define SEL7_LSB 9
`define LINE_SELECT_BITS 12
`define ANALOG_BITS 8
`define CHANNEL_COUNT 4

// ==========================================================
// Port 3 selector codes
`define SEL3_RTC 3'h0
`define SEL3_USB 3'h1

// ==========================================================
// Reset values
`define RST_LINE_SELECT 12'h000
`define RST_ANALOG_ENABLE 8'h00
`define RST_EVENT_MASK 4'h0

`endif

// [wakeup_route_pkg.sv]
// Types shared by the wake-up routing block
package wakeup_route_pkg;
  `include "wakeup_route_cfg.svh"

  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_type;

  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    resp_type bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    resp_type rresp;
    logic [`LINE_SELECT_BITS-1:0] line_select;
    logic [`ANALOG_BITS-1:0] analog_enable;
    logic [`CHANNEL_COUNT-1:0] event_status;
    logic [`CHANNEL_COUNT-1:0] event_mask;
    logic [`CHANNEL_COUNT-1:0] channel_prev;
    logic irq;
  } state_type;
endpackage : wakeup_route_pkg

// [wakeup_route_mux.sv]
// Combinational source selectors for interrupt channels 10 to 13
`timescale 1ns/1ps
`include "wakeup_route_cfg.svh"

module wakeup_route_mux (
  input wire logic [31:0] ext_lines,
  input wire logic rtc_event,
  input wire logic usb_resume_event,
  input wire logic [`LINE_SELECT_BITS-1:0] line_select,
  output logic [`CHANNEL_COUNT-1:0] channel_out
);

  // ==========================================================
  // Ports 5, 6 and 7: line group i, index = 8*i + code
  // No register stage, so a new code steers the line at once
  for (genvar i = 1; i < `CHANNEL_COUNT; i++) begin : g_group
    localparam logic [1:0] GROUP = 2'(i);
    logic [`SEL_WIDTH-1:0] code;
    assign code = line_select[`SEL_WIDTH*i +: `SEL_WIDTH];
    assign channel_out[i] = ext_lines[{GROUP, code}];
  end

  // ==========================================================
  // Port 3: two on-chip events, then lines 2 to 7
  // Bit 0 goes through its own net so that no process shares the output vector
  logic [`SEL_WIDTH-1:0] code3;
  logic ch10;
  assign code3 = line_select[`SEL3_LSB +: `SEL_WIDTH];
  assign channel_out[0] = ch10;

  always_comb begin
    case (code3)
      `SEL3_RTC: ch10 = rtc_event;
      `SEL3_USB: ch10 = usb_resume_event;
      default: ch10 = ext_lines[{2'h0, code3}];
    endcase
  end

endmodule : wakeup_route_mux

// [wakeup_source_select_analog_ctrl.sv]
// Wake-up line routing, port 4 analog enables and their AXI4-Lite register slave
// Operation
// - Port 7 code picks lines 24-31, channel 13
// - Port 6 code picks lines 16-23, channel 12
// - Port 5 code picks lines 8-15, channel 11
// - Port 3: RTC, USB resume, lines 2-7
// - Unused upper register bits read as zero
// - Selection fields writable, readable, steer routing
// - Analog bit one puts port 4 pin analog
// - Both registers reset to zero
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wakeup_route_cfg.svh"

module wakeup_source_select_analog_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [31:0] ext_lines,
  input wire logic rtc_event,
  input wire logic usb_resume_event,
  output logic [`CHANNEL_COUNT-1:0] channel_out,
  output logic [`ANALOG_BITS-1:0] port4_pin_analog_bits,
  output logic irq
);

  wakeup_route_pkg::state_type state_reg;
  wakeup_route_pkg::state_type state_next;

  logic wr_fire;
  logic rd_fire;
  logic [`CHANNEL_COUNT-1:0] channel_rise;

  // ==========================================================
  // Routing
  // Channel outputs bypass the state flops on purpose: the interrupt
  // controller must see the pad line itself, not a delayed copy
  wakeup_route_mux u_mux (
    .ext_lines(ext_lines),
    .rtc_event(rtc_event),
    .usb_resume_event(usb_resume_event),
    .line_select(state_reg.line_select),
    .channel_out(channel_out)
  );

  assign channel_rise = channel_out & ~state_reg.channel_prev;
  assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_fire = arvalid && state_reg.arready;

  // ==========================================================
  // Next state
  always_comb begin
    logic [`CHANNEL_COUNT-1:0] clear_bits;
    clear_bits = '0;
    state_next = state_reg;
    state_next.channel_prev = channel_out;

    // Address and data may arrive in either order; each is parked
    if (awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end

    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wakeup_route_pkg::RESP_OKAY;
      case (state_reg.aw_addr)
        `OFS_LINE_SELECT: begin
          if (state_reg.w_strb[0]) begin
            state_next.line_select[7:0] = state_reg.w_data[7:0];
          end
          if (state_reg.w_strb[1]) begin
            state_next.line_select[11:8] = state_reg.w_data[11:8];
          end
        end
        `OFS_ANALOG_ENABLE: begin
          if (state_reg.w_strb[0]) begin
            state_next.analog_enable = state_reg.w_data[7:0];
          end
        end
        `OFS_EVENT_STATUS: begin
          if (state_reg.w_strb[0]) begin
            clear_bits = state_reg.w_data[`CHANNEL_COUNT-1:0];
          end
        end
        `OFS_EVENT_MASK: begin
          if (state_reg.w_strb[0]) begin
            state_next.event_mask = state_reg.w_data[`CHANNEL_COUNT-1:0];
          end
        end
        default: begin
          state_next.bresp = wakeup_route_pkg::RESP_SLVERR;
        end
      endcase
    end

    // A rising edge in the same cycle as its clear keeps the bit set
    state_next.event_status = (state_reg.event_status & ~clear_bits) | channel_rise;

    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = wakeup_route_pkg::RESP_OKAY;
      state_next.rdata = '0;
      case (araddr)
        `OFS_LINE_SELECT: state_next.rdata[`LINE_SELECT_BITS-1:0] = state_reg.line_select;
        `OFS_ANALOG_ENABLE: state_next.rdata[`ANALOG_BITS-1:0] = state_reg.analog_enable;
        `OFS_EVENT_STATUS: state_next.rdata[`CHANNEL_COUNT-1:0] = state_reg.event_status;
        `OFS_EVENT_MASK: state_next.rdata[`CHANNEL_COUNT-1:0] = state_reg.event_mask;
        default: state_next.rresp = wakeup_route_pkg::RESP_SLVERR;
      endcase
    end

    // Only one write and one read in flight; ready drops until the answer is taken
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;
    state_next.arready = !state_next.rvalid;
    state_next.irq = |(state_next.event_status & state_next.event_mask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // Software must clear the pin's input-connect and output-control bits
  // before raising an analog bit; this block does not interlock them
  assign port4_pin_analog_bits = state_reg.analog_enable;
  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
  assign irq = state_reg.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sel_write;
    wr_fire && (state_reg.aw_addr == `OFS_LINE_SELECT) && (state_reg.w_strb[1:0] == 2'h3);
  endsequence

  sequence s_ana_write;
    wr_fire && (state_reg.aw_addr == `OFS_ANALOG_ENABLE) && state_reg.w_strb[0];
  endsequence

  sequence s_sel_read;
    rd_fire && (araddr == `OFS_LINE_SELECT);
  endsequence

  sequence s_ana_read;
    rd_fire && (araddr == `OFS_ANALOG_ENABLE);
  endsequence

  sequence s_stat_clear;
    wr_fire && (state_reg.aw_addr == `OFS_EVENT_STATUS) && state_reg.w_strb[0];
  endsequence

  sequence s_mask_write;
    wr_fire && (state_reg.aw_addr == `OFS_EVENT_MASK) && state_reg.w_strb[0];
  endsequence

  a_port7_route: assert property (channel_out[3] == ext_lines[5'h18 + 5'(state_reg.line_select[11:9])])
    else $error("channel 13 does not follow port 7 code");

  a_port6_route: assert property (channel_out[2] == ext_lines[5'h10 + 5'(state_reg.line_select[8:6])])
    else $error("channel 12 does not follow port 6 code");

  a_port5_route: assert property ($changed(state_reg.line_select[5:3]) |->
    channel_out[1] == ext_lines[5'h08 + 5'(state_reg.line_select[5:3])])
    else $error("channel 11 lags port 5 code change");

  a_port3_route: assert property (
    (state_reg.line_select[2:0] == 3'h0 && channel_out[0] == rtc_event) ||
    (state_reg.line_select[2:0] == 3'h1 && channel_out[0] == usb_resume_event) ||
    (state_reg.line_select[2:0] > 3'h1 && channel_out[0] == ext_lines[5'(state_reg.line_select[2:0])]))
    else $error("channel 10 source wrong");

  a_upper_zero: assert property (rvalid |-> rdata[31:12] == 20'h00000)
    else $error("upper read bits not zero");

  a_sel_write: assert property (s_sel_write |=> state_reg.line_select == $past(state_reg.w_data[11:0]))
    else $error("selection write not stored");

  a_sel_readback: assert property (s_sel_read ##1 1 |-> rdata[11:0] == $past(state_reg.line_select))
    else $error("selection readback wrong");

  a_analog_write: assert property (s_ana_write |=> port4_pin_analog_bits == $past(state_reg.w_data[7:0]))
    else $error("analog write not on pins");

  a_reset_zero: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> (state_reg.line_select == 12'h000 && port4_pin_analog_bits == 8'h00 && !irq))
    else $error("registers not zero after reset");

  a_event_sticky: assert property ((|channel_rise) |=> (state_reg.event_status & $past(channel_rise)) == $past(channel_rise))
    else $error("event lost");

  a_irq_level: assert property (irq == |(state_reg.event_status & state_reg.event_mask))
    else $error("irq disagrees with status and mask");

  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  a_ana_upper: assert property (s_ana_read |=> rdata[31:8] == 24'h000000)
    else $error("analog register upper read bits not zero");

  a_ana_readback: assert property (s_ana_read |=> rdata[7:0] == $past(state_reg.analog_enable))
    else $error("analog readback wrong");

  a_analog_hold: assert property (
    !(wr_fire && (state_reg.aw_addr == `OFS_ANALOG_ENABLE)) |=> $stable(port4_pin_analog_bits))
    else $error("analog pins changed without a write");

  a_sel_hold: assert property (
    !(wr_fire && (state_reg.aw_addr == `OFS_LINE_SELECT)) |=> $stable(state_reg.line_select))
    else $error("selection changed without a write");

  a_stat_clear: assert property (
    s_stat_clear |=> (state_reg.event_status & $past(state_reg.w_data[3:0] & ~channel_rise)) == 4'h0)
    else $error("event status bit not cleared");

  a_mask_write: assert property (s_mask_write |=> state_reg.event_mask == $past(state_reg.w_data[3:0]))
    else $error("mask write not stored");

  a_mask_off: assert property (state_reg.event_mask == 4'h0 |-> !irq)
    else $error("irq raised with every channel masked");

  // ==========================================================
  // Register bus handshake
  sequence s_bad_write;
    wr_fire && !(state_reg.aw_addr inside
      {`OFS_LINE_SELECT, `OFS_ANALOG_ENABLE, `OFS_EVENT_STATUS, `OFS_EVENT_MASK});
  endsequence

  sequence s_bad_read;
    rd_fire && !(araddr inside
      {`OFS_LINE_SELECT, `OFS_ANALOG_ENABLE, `OFS_EVENT_STATUS, `OFS_EVENT_MASK});
  endsequence

  a_write_answer: assert property (wr_fire |=> bvalid)
    else $error("write executed without a response");

  a_read_answer: assert property (rd_fire |=> rvalid)
    else $error("read taken without a response");

  a_bad_write: assert property (s_bad_write |=> bresp == 2'h2)
    else $error("unmapped write not answered with slave error");

  a_bad_read: assert property (s_bad_read |=> rresp == 2'h2 && rdata == 32'h00000000)
    else $error("unmapped read not answered with slave error");

  a_wr_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready while response pending");

  a_rd_refused: assert property (rvalid |-> !arready)
    else $error("read address ready while data pending");

  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped or changed");

  a_reset_idle: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !awready && !wready && !arready && !bvalid && !rvalid)
    else $error("bus not idle after reset");

endmodule : wakeup_source_select_analog_ctrl

// [wake_unit_model.sv]
// Behavioural wake-up unit that sits behind the four routed channels
`timescale 1ns/1ps
module wake_unit_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] channel_out,
  output logic [3:0] wake_seen
);
  // ==========================================================
  // Sticky record of every channel seen high, cleared only by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_seen <= 4'h0;
    end else begin
      wake_seen <= wake_seen | channel_out;
    end
  end
endmodule : wake_unit_model

// [test_wakeup_source_select_analog_ctrl.sv]
// Self-checking bench for the wake-up routing and port 4 analog enable block
`timescale 1ns/1ps
`include "wakeup_route_cfg.svh"
module test_wakeup_source_select_analog_ctrl;
  // ==========================================================
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rtc_event, usb_resume_event;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ext_lines, v;
  logic [3:0] wstrb, channel_out, wake_seen, exp_ch;
  logic [1:0] bresp, rresp;
  logic [7:0] port4_pin_analog_bits;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int errors, num_checks, cycles;

  wakeup_source_select_analog_ctrl wakeup_source_select_analog_ctrl_inst (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .ext_lines, .rtc_event, .usb_resume_event,
    .channel_out, .port4_pin_analog_bits, .irq);
  wake_unit_model wake_unit_model_inst (.aclk, .aresetn, .channel_out, .wake_seen);

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // ==========================================================
  // Reporting
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // ==========================================================
  // Bus master; each task starts one edge after the last so no signal is driven twice in a step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    exp_b.push_back(r);
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (awvalid || wvalid);
    while (!bvalid) @(posedge aclk);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    exp_r.push_back(e);
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
  endtask : rd

  // ==========================================================
  // Response monitor and hang guard
  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, usb_resume_event} = 7'h00;
    rtc_event = 1'h1;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    ext_lines = 32'h01010100;
    void'($urandom(32'hC5D4F8D4));
    repeat (20) @(posedge aclk);
    check(channel_out, 4'hF);
    check(port4_pin_analog_bits, 8'h00);
    aresetn <= 1'h1;
    rd(`OFS_LINE_SELECT, 34'h0);
    rd(`OFS_ANALOG_ENABLE, 34'h0);
    repeat (4) begin
      v = $urandom();
      wr(`OFS_LINE_SELECT, v, 2'h0);
      rd(`OFS_LINE_SELECT, {2'h0, v & 32'hFFF});
      // Software has already cleared the pin's GPIO connect and drive bits here
      wr(`OFS_ANALOG_ENABLE, v, 2'h0);
      rd(`OFS_ANALOG_ENABLE, {2'h0, v & 32'hFF});
      check(port4_pin_analog_bits, v[7:0]);
    end
    wr(12'h0A0, v, 2'h2);
    rd(12'h0A0, {2'h2, 32'h0});
    // Reset again mid-run with quiet lines, so the far side starts the sweep having seen nothing
    @(posedge aclk);
    aresetn <= 1'h0;
    ext_lines <= 32'h0;
    rtc_event <= 1'h0;
    repeat (2) @(posedge aclk);
    check(wake_seen, 4'h0);
    check(port4_pin_analog_bits, 8'h00);
    aresetn <= 1'h1;
    rd(`OFS_ANALOG_ENABLE, 34'h0);
    rd(`OFS_LINE_SELECT, 34'h0);
    // Every code on all four selectors at once, inputs changed at the clock edge and checked 1 ns later to expose any register stage
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_LINE_SELECT, {20'h0, c[2:0], c[2:0], c[2:0], c[2:0]}, 2'h0);
      repeat (3) begin
        @(posedge aclk);
        v = $urandom();
        ext_lines <= $urandom();
        rtc_event <= v[0];
        usb_resume_event <= v[1];
        #1;
        exp_ch = {ext_lines[24 + c], ext_lines[16 + c], ext_lines[8 + c],
          c == 0 ? rtc_event : (c == 1 ? usb_resume_event : ext_lines[c])};
        check(channel_out, exp_ch);
      end
    end
    check(wake_seen, 4'hF);
    // Interrupt: raise, masked, unmasked, cleared
    @(posedge aclk);
    ext_lines <= 32'h0;
    rtc_event <= 1'h0;
    usb_resume_event <= 1'h0;
    wr(`OFS_LINE_SELECT, 32'h0, 2'h0);
    wr(`OFS_EVENT_STATUS, 32'hF, 2'h0);
    rd(`OFS_EVENT_STATUS, 34'h0);
    @(posedge aclk);
    rtc_event <= 1'h1;
    rd(`OFS_EVENT_STATUS, 34'h1);
    check(irq, 1'h0);
    wr(`OFS_EVENT_MASK, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    check(irq, 1'h1);
    wr(`OFS_EVENT_STATUS, 32'h1, 2'h0);
    rd(`OFS_EVENT_STATUS, 34'h0);
    check(irq, 1'h0);
    print_verdict();
  end
endmodule : test_wakeup_source_select_analog_ctrl
